// ===== verilog/gmd_defs.svh
`ifndef GMD_DEFS_SVH
`define GMD_DEFS_SVH
`define GMD_IDX_MISC 10'h0A2
`define GMD_IDX_BW 10'h0A6
`define GMD_IDX_PROMO 10'h0A8
`define GMD_IDX_RSVD 10'h0AA
`define GMD_MISC_MERGE 0
`define GMD_MISC_PRIMASK 1
`define GMD_MISC_HOLD 2
`define GMD_MISC_MASK 3'h7
`define GMD_PROMO_MASK 16'h3FFF
`define GMD_BW_MASK 16'hFFF0
`define GMD_PROMO_LSB0 12
`define GMD_BW_LSB0 14
`define GMD_PIPE_GFX 1
`define GMD_PIPE_DISP 0
`define GMD_RESET_VAL 16'h0000
`define GMD_STEP_CYCLES 3
`define GMD_MERGE_QW 5'h08
`endif

// ===== verilog/gmd_pkg.sv
package gmd_pkg;
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] qwords;
        logic isWrite;
        logic highPri;
        logic [2:0] source;
    } gfx_req_type;
    typedef struct packed {
        logic [31:0] addr;
        logic [3:0] qwords;
    } disp_req_type;
    typedef struct packed {
        logic [2:0] source;
        logic [1:0] slot;
        logic [127:0] data;
    } ret_beat_type;
    typedef struct packed {
        logic [2:0] source;
        logic [127:0] data;
    } gfx_data_type;
endpackage

// ===== verilog/gfx_memory_request_dispatcher.sv
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "gmd_defs.svh"
module gfx_memory_request_dispatcher #(
    parameter int SOURCES = 6
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // test pin
    input wire logic testHoldPin,
    // graphics engine requests
    input wire logic gfxReqValid,
    input wire gmd_pkg::gfx_req_type gfxReq,
    output logic gfxReqReady,
    // requests to dram controller
    output logic dramReqValid,
    output gmd_pkg::gfx_req_type dramReq,
    input wire logic dramReqReady,
    // display engine requests
    input wire logic dispReqValid,
    input wire gmd_pkg::disp_req_type dispReq,
    output logic dispOutValid,
    output gmd_pkg::disp_req_type dispOut,
    // returned data from dram controller
    input wire logic retValid,
    input wire gmd_pkg::ret_beat_type ret,
    output logic retReady,
    // reordered data to graphics engines
    output logic gfxDataValid,
    output gmd_pkg::gfx_data_type gfxData
);
    import gmd_pkg::*;

    function automatic logic [5:0] limitOf(input logic [1:0] code);
        limitOf = {({1'b0, code} + 3'h1), `GMD_STEP_CYCLES'h0};
    endfunction

    // registers
    logic [2:0] misc, next_misc;
    logic [15:0] promoWord, next_promoWord;
    logic [15:0] bwWord, next_bwWord;
    logic [31:0] next_prdata, rdVal;
    logic hit;

    always_comb begin
        hit = (paddr[1:0] == 2'h0);
        rdVal = 32'h0000_0000;
        unique case (paddr[11:2])
            `GMD_IDX_MISC: rdVal = {29'h0, misc};
            `GMD_IDX_BW: rdVal = {16'h0, bwWord};
            `GMD_IDX_PROMO: rdVal = {16'h0, promoWord};
            `GMD_IDX_RSVD: rdVal = 32'h0000_0000;
            default: hit = 1'b0;
        endcase
        next_misc = misc;
        next_promoWord = promoWord;
        next_bwWord = bwWord;
        if (psel && penable && pwrite && hit) begin
            if (paddr[11:2] == `GMD_IDX_MISC) next_misc = pwdata[2:0] & `GMD_MISC_MASK;
            if (paddr[11:2] == `GMD_IDX_BW) next_bwWord = pwdata[15:0] & `GMD_BW_MASK;
            if (paddr[11:2] == `GMD_IDX_PROMO) next_promoWord = pwdata[15:0] & `GMD_PROMO_MASK;
        end
        next_prdata = (psel && !penable) ? (hit ? rdVal : 32'h0000_0000) : prdata;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            misc <= 3'h0;
            promoWord <= `GMD_RESET_VAL;
            bwWord <= `GMD_RESET_VAL;
            prdata <= 32'h0000_0000;
        end else begin
            misc <= next_misc;
            promoWord <= next_promoWord;
            bwWord <= next_bwWord;
            prdata <= next_prdata;
        end
    end

    assign pready = psel & penable;
    assign pslverr = psel & penable & ~hit;

    // request path
    logic holdActive, pipeGfx, pipeDisp, mergeEn, priMask;
    logic stageFull, next_stageFull, outValid, next_outValid;
    gfx_req_type stageReq, next_stageReq, outReq, next_outReq, eff;
    logic effValid, canMerge, outFree, effTake;
    logic [4:0] qwSum;

    assign holdActive = misc[`GMD_MISC_HOLD] & ~testHoldPin;
    assign mergeEn = misc[`GMD_MISC_MERGE];
    assign priMask = misc[`GMD_MISC_PRIMASK];
    assign pipeGfx = promoWord[`GMD_PIPE_GFX];
    assign pipeDisp = promoWord[`GMD_PIPE_DISP];

    always_comb begin
        effValid = stageFull | (pipeGfx & gfxReqValid);
        eff = stageFull ? stageReq : gfxReq;
        qwSum = {1'b0, eff.qwords} + {1'b0, outReq.qwords};
        outFree = ~outValid | dramReqReady;
        // only a request still waiting downstream can grow, so merging never adds latency
        canMerge = mergeEn & outValid & ~dramReqReady & (eff.source == outReq.source)
            & (eff.isWrite == outReq.isWrite) & (qwSum <= `GMD_MERGE_QW)
            & (eff.addr == outReq.addr + {25'h0, outReq.qwords, 3'h0});
        effTake = effValid & ~holdActive & (outFree | canMerge);
        gfxReqReady = pipeGfx ? (~stageFull & effTake) : (~stageFull | effTake);
        next_stageFull = stageFull;
        next_stageReq = stageReq;
        if (!pipeGfx && gfxReqValid && gfxReqReady) begin
            next_stageFull = 1'b1;
            next_stageReq = gfxReq;
        end else if (stageFull && effTake) begin
            next_stageFull = 1'b0;
        end
        next_outValid = outValid;
        next_outReq = outReq;
        if (effTake && canMerge) begin
            next_outReq.qwords = qwSum[3:0];
            next_outReq.highPri = outReq.highPri | eff.highPri;
        end else if (effTake) begin
            next_outValid = 1'b1;
            next_outReq = eff;
        end else if (dramReqReady) begin
            next_outValid = 1'b0;
        end
        dramReq = outReq;
        dramReq.highPri = outReq.highPri & ~priMask;
    end

    assign dramReqValid = outValid;

    // display path
    logic dispStageValid, next_dispStageValid;
    disp_req_type dispStage, next_dispStage;

    always_comb begin
        next_dispStageValid = dispReqValid;
        next_dispStage = dispReq;
        dispOutValid = pipeDisp ? dispReqValid : dispStageValid;
        dispOut = pipeDisp ? dispReq : dispStage;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            stageFull <= 1'b0;
            stageReq <= '0;
            outValid <= 1'b0;
            outReq <= '0;
            dispStageValid <= 1'b0;
            dispStage <= '0;
        end else begin
            stageFull <= next_stageFull;
            stageReq <= next_stageReq;
            outValid <= next_outValid;
            outReq <= next_outReq;
            dispStageValid <= next_dispStageValid;
            dispStage <= next_dispStage;
        end
    end

    // return path: per-source reorder slots and arbiter
    logic [127:0] dataMem [SOURCES][4];
    logic [127:0] next_dataMem [SOURCES][4];
    logic [3:0] slotFull [SOURCES];
    logic [3:0] next_slotFull [SOURCES];
    logic [1:0] headPtr [SOURCES];
    logic [1:0] next_headPtr [SOURCES];
    logic [SOURCES-1:0] headReady, promoted;
    logic [2:0] owner, next_owner, rrPtr, next_rrPtr, serveSrc, cand;
    logic ownerActive, next_ownerActive, serveValid, serveNew, keep, othersReady, found;
    logic [5:0] burstCnt, next_burstCnt, ownerLimit;
    logic next_gfxDataValid;
    gfx_data_type next_gfxData;

    always_comb begin
        for (int s = 0; s < SOURCES; s++) begin
            headReady[s] = slotFull[s][headPtr[s]];
        end
        retReady = ~slotFull[ret.source][ret.slot];
        ownerLimit = limitOf(bwWord[`GMD_BW_LSB0 - 2 * owner +: 2]);
        othersReady = |(headReady & ~(6'h01 << owner));
        keep = ownerActive & headReady[owner] & ((burstCnt < ownerLimit) | ~othersReady);
        found = 1'b0;
        serveSrc = owner;
        // an owner within its burst limit, or alone, keeps the grant; else promoted streams first, then the normal engine, both rotating from the last grant
        for (int i = 1; i <= SOURCES; i++) begin
            cand = 3'((int'(rrPtr) + i) % SOURCES);
            if (!found && headReady[cand] && promoted[cand]) begin
                found = 1'b1;
                serveSrc = cand;
            end
        end
        for (int i = 1; i <= SOURCES; i++) begin
            cand = 3'((int'(rrPtr) + i) % SOURCES);
            if (!found && headReady[cand]) begin
                found = 1'b1;
                serveSrc = cand;
            end
        end
        if (keep) serveSrc = owner;
        serveValid = keep | found;
        serveNew = serveValid & ~keep;
        next_slotFull = slotFull;
        next_dataMem = dataMem;
        next_headPtr = headPtr;
        if (retValid && retReady) begin
            next_slotFull[ret.source][ret.slot] = 1'b1;
            next_dataMem[ret.source][ret.slot] = ret.data;
        end
        next_gfxDataValid = serveValid;
        next_gfxData = gfxData;
        if (serveValid) begin
            next_gfxData.source = serveSrc;
            next_gfxData.data = dataMem[serveSrc][headPtr[serveSrc]];
            next_slotFull[serveSrc][headPtr[serveSrc]] = 1'b0;
            next_headPtr[serveSrc] = headPtr[serveSrc] + 2'h1;
        end
        next_ownerActive = serveValid;
        next_owner = serveValid ? serveSrc : owner;
        next_rrPtr = serveNew ? serveSrc : rrPtr;
        next_burstCnt = keep ? burstCnt + 6'h01 : (serveNew ? 6'h01 : 6'h00);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int s = 0; s < SOURCES; s++) begin
                slotFull[s] <= 4'h0;
                headPtr[s] <= 2'h0;
                for (int k = 0; k < 4; k++) dataMem[s][k] <= '0;
            end
            owner <= 3'h0;
            rrPtr <= 3'(SOURCES - 1);
            ownerActive <= 1'b0;
            burstCnt <= 6'h00;
            gfxDataValid <= 1'b0;
            gfxData <= '0;
        end else begin
            slotFull <= next_slotFull;
            headPtr <= next_headPtr;
            dataMem <= next_dataMem;
            owner <= next_owner;
            rrPtr <= next_rrPtr;
            ownerActive <= next_ownerActive;
            burstCnt <= next_burstCnt;
            gfxDataValid <= next_gfxDataValid;
            gfxData <= next_gfxData;
        end
    end

    // promotion timers
    for (genvar s = 0; s < SOURCES; s++) begin : gen_promo
        logic [5:0] cnt, next_cnt, lim;
        logic next_prom, served;
        always_comb begin
            lim = limitOf(promoWord[`GMD_PROMO_LSB0 - 2 * s +: 2]);
            served = serveValid & (serveSrc == 3'(s));
            next_cnt = 6'h00;
            next_prom = promoted[s] & ~(serveNew & served);
            if (headReady[s] && !promoted[s] && !served) begin
                if (cnt + 6'h01 >= lim) begin
                    next_prom = 1'b1;
                end else begin
                    next_cnt = cnt + 6'h01;
                end
            end
        end
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                cnt <= 6'h00;
                promoted[s] <= 1'b0;
            end else begin
                cnt <= next_cnt;
                promoted[s] <= next_prom;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_hold_stalls: assert property (holdActive |-> !effTake && !(pipeGfx && gfxReqReady))
        else $error("request taken while test hold active");
    chk_prio_masked: assert property (dramReqValid && priMask |-> !dramReq.highPri)
        else $error("high priority leaked through mask");
    chk_prio_kept: assert property (effTake && !canMerge && !priMask ##1 !priMask |-> dramReq.highPri == $past(eff.highPri))
        else $error("priority not carried downstream");
    chk_merge_off: assert property (!mergeEn && effTake |=> dramReq.qwords == $past(eff.qwords))
        else $error("request changed with merging off");
    chk_merge_size: assert property (dramReqValid |-> dramReq.qwords <= 4'h8)
        else $error("merged request above eight quadwords");
    chk_promo_wait: assert property ($rose(promoted[0]) |-> $past(headReady[0], 8))
        else $error("promotion before eight clocks of waiting");
    chk_burst_cap: assert property (ownerActive && serveValid && serveSrc == owner && othersReady |-> burstCnt < ownerLimit)
        else $error("owner exceeded bandwidth with others waiting");
    chk_no_limit: assert property (ownerActive && headReady[owner] && !othersReady |=> gfxDataValid && gfxData.source == $past(owner))
        else $error("lone stream was cut off");
    chk_gfx_stage: assert property (!pipeGfx && gfxReqValid && gfxReqReady |=> stageFull && stageReq == $past(gfxReq))
        else $error("graphics stage not inserted");
    chk_disp_stage: assert property (!pipeDisp ##1 !pipeDisp |-> dispOutValid == $past(dispReqValid))
        else $error("display stage not inserted");
    chk_serve_head: assert property (serveValid |-> headReady[serveSrc])
        else $error("served a source without in-order head data");
endmodule // gfx_memory_request_dispatcher

// ===== bench/dram_side_model.sv
`timescale 1ns/1ps
module dram_side_model (
    // clock
    input wire logic clk_sys,
    // request side
    input wire logic dramReqValid,
    input wire gmd_pkg::gfx_req_type dramReq,
    output logic dramReqReady,
    input wire logic stall,
    // return side
    output logic retValid,
    output gmd_pkg::ret_beat_type ret,
    input wire logic retReady
);
    import gmd_pkg::*;
    int taken = 0;
    gfx_req_type lastReq = '0;
    // a stalled controller leaves a request waiting, which is when merging may happen
    assign dramReqReady = ~stall;
    initial begin
        retValid = 1'h0;
        ret = '0;
    end
    always @(posedge clk_sys) begin
        if (dramReqValid === 1'h1 && dramReqReady) begin
            taken <= taken + 1;
            lastReq <= dramReq;
        end
    end
    // slots may come back in any order, the dispatcher must put them right
    task beat(input logic [2:0] src, input logic [1:0] slot, input logic [31:0] d);
        retValid <= 1'h1;
        ret <= '{source: src, slot: slot, data: {96'h0, d}};
        // the beat is taken at the edge where ready is seen high; only the bench watchdog ends a wait
        do @(posedge clk_sys); while (retReady !== 1'h1);
        retValid <= 1'h0;
        ret <= ~ret;
        @(posedge clk_sys);
    endtask
endmodule // dram_side_model

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import gmd_pkg::*;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic testHoldPin = 1, gfxReqValid = 0, gfxReqReady, dramReqValid, dramReqReady, stall = 0;
    logic dispReqValid = 0, dispOutValid, retValid, retReady, gfxDataValid;
    gfx_req_type gfxReq = '0, dramReq;
    disp_req_type dispReq = '0, dispOut;
    ret_beat_type ret;
    gfx_data_type gfxData;
    int fails = 0, checked = 0, n, base;
    logic [34:0] seen[$];
    always #20 clk_sys = ~clk_sys;
    gfx_memory_request_dispatcher gfx_memory_request_dispatcher_i (.clk_sys(clk_sys), .rst(rst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .testHoldPin(testHoldPin), .gfxReqValid(gfxReqValid),
        .gfxReq(gfxReq), .gfxReqReady(gfxReqReady), .dramReqValid(dramReqValid), .dramReq(dramReq),
        .dramReqReady(dramReqReady), .dispReqValid(dispReqValid), .dispReq(dispReq),
        .dispOutValid(dispOutValid), .dispOut(dispOut), .retValid(retValid), .ret(ret),
        .retReady(retReady), .gfxDataValid(gfxDataValid), .gfxData(gfxData));
    dram_side_model dram_side_model_i (.clk_sys(clk_sys), .dramReqValid(dramReqValid), .dramReq(dramReq),
        .dramReqReady(dramReqReady), .stall(stall), .retValid(retValid), .ret(ret), .retReady(retReady));
    always @(negedge clk_sys) if (gfxDataValid === 1'h1) seen.push_back({gfxData.source, gfxData.data[31:0]});
    task check(input string nm, input logic [34:0] exp, input logic [34:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'h1;
        // read data and response are taken at the very edge where pready is seen high
        do @(posedge clk_sys); while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk_sys);
    endtask
    task rd(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic expErr);
        apb(1'h0, a, 32'h0);
        check(nm, exp, q);
        check("error response", expErr, err);
    endtask
    task send(input logic [31:0] a, input logic [3:0] qw, input logic hi);
        gfxReqValid <= 1'h1;
        gfxReq <= '{addr: a, qwords: qw, isWrite: 1'h0, highPri: hi, source: 3'h3};
        do @(posedge clk_sys); while (gfxReqReady !== 1'h1);
        gfxReqValid <= 1'h0;
        gfxReq <= ~gfxReq;
    endtask
    task lat(input int exp);
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (dramReqValid !== 1'h1 && n < 9);
        check("request latency", exp, n);
        repeat (3) @(posedge clk_sys);
    endtask
    task disp(input logic direct, input logic [31:0] a);
        logic [31:0] old;
        old = dispReq.addr;
        dispReqValid <= 1'h1;
        dispReq <= '{addr: a, qwords: 4'h4};
        @(negedge clk_sys);
        check("display same cycle", direct ? a : old, dispOut.addr);
        @(negedge clk_sys);
        check("display next cycle", a, dispOut.addr);
        @(posedge clk_sys);
    endtask
    task pair(input logic merge, input int expTaken, input logic [3:0] expQw);
        apb(1'h1, 12'h288, {31'h0, merge});
        stall <= merge;
        base = dram_side_model_i.taken;
        send(32'h400, 4'h4, 1'h0);
        @(posedge clk_sys);
        send(32'h420, 4'h4, 1'h0);
        repeat (4) @(posedge clk_sys);
        stall <= 1'h0;
        repeat (8) @(posedge clk_sys);
        check("forwarded count", expTaken, dram_side_model_i.taken - base);
        check("forwarded size", expQw, dram_side_model_i.lastReq.qwords);
    endtask
    task hold(input logic en, input logic pin, input logic exp);
        apb(1'h1, 12'h288, {29'h0, en, 2'h0});
        testHoldPin <= pin;
        // ready only means something while a request is offered
        gfxReqValid <= 1'h1;
        gfxReq <= '{addr: 32'h600, qwords: 4'h2, isWrite: 1'h0, highPri: 1'h0, source: 3'h3};
        @(posedge clk_sys);
        check("request ready", exp, gfxReqReady);
        if (gfxReqReady !== 1'h1) begin
            testHoldPin <= 1'h1;
            do @(posedge clk_sys); while (gfxReqReady !== 1'h1);
        end
        gfxReqValid <= 1'h0;
        testHoldPin <= 1'h1;
        @(posedge clk_sys);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        rd("misc reset", 12'h288, 32'h0, 1'h0);
        rd("bandwidth reset", 12'h298, 32'h0, 1'h0);
        rd("promotion reset", 12'h2A0, 32'h0, 1'h0);
        rd("reserved pair", 12'h2A8, 32'h0, 1'h0);
        rd("unmapped", 12'h004, 32'h0, 1'h1);
        $display("test register reset done");
        disp(1'h0, 32'h1000);
        send(32'h100, 4'h4, 1'h1);
        lat(2);
        check("priority passed", 1'h1, dram_side_model_i.lastReq.highPri);
        apb(1'h1, 12'h288, 32'h2);
        send(32'h140, 4'h2, 1'h1);
        repeat (6) @(posedge clk_sys);
        check("priority masked", 1'h0, dram_side_model_i.lastReq.highPri);
        $display("test staged paths done");
        apb(1'h1, 12'h2A0, 32'hFFFF);
        rd("promotion fields", 12'h2A0, 32'h3FFF, 1'h0);
        apb(1'h1, 12'h298, 32'hFFFF);
        rd("bandwidth fields", 12'h298, 32'hFFF0, 1'h0);
        apb(1'h1, 12'h288, 32'hFFFF);
        rd("misc fields", 12'h288, 32'h7, 1'h0);
        $display("test register fields done");
        apb(1'h1, 12'h288, 32'h0);
        send(32'h200, 4'h2, 1'h0);
        lat(1);
        disp(1'h1, 32'h2000);
        pair(1'h0, 2, 4'h4);
        pair(1'h1, 1, 4'h8);
        $display("test direct paths and merging done");
        hold(1'h1, 1'h0, 1'h0);
        hold(1'h1, 1'h1, 1'h1);
        hold(1'h0, 1'h0, 1'h1);
        hold(1'h0, 1'h1, 1'h1);
        $display("test hold done");
        seen.delete();
        dram_side_model_i.beat(3'h2, 2'h1, 32'h22220001);
        dram_side_model_i.beat(3'h2, 2'h0, 32'h22220000);
        repeat (12) @(posedge clk_sys);
        check("beats delivered", 35'h2, seen.size());
        check("first beat", {3'h2, 32'h22220000}, seen[0]);
        check("second beat", {3'h2, 32'h22220001}, seen[1]);
        $display("test return order done");
        conclude();
    end
endmodule // testbench
